// ==== include/gain_switch_params.svh ====
// Constants of the gain switch selector: offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from the selector design file.
`ifndef GAIN_SWITCH_PARAMS_SVH
`define GAIN_SWITCH_PARAMS_SVH
`define GS_CLK_PERIOD_NS 4
`define GS_WINDOW_NS 166000
`define GS_WINDOW_CYCLES (`GS_WINDOW_NS / `GS_CLK_PERIOD_NS)
`define GS_REG_COUNT 8
`define GS_STATUS_INDEX 4'h8
`define GS_CTRL_EN_BIT 0
`define GS_CTRL_SEL_LSB 4
`define GS_MODE_AUTOTUNE_LSB 4
`define GS_HI_FIELD_LSB 16
`define GS_RST_TFILT 32'h0098_0098
`define GS_RST_NOTCH 32'h0002_05dc
`define GS_NOTCH_OFF_FREQ 16'h05dc
`define GS_VIB_MIN_VALID 16'h0064
`define GS_RESP_OKAY 2'h0
`define GS_RESP_DECERR 2'h3
`endif

// ==== include/gain_switch_pkg.sv ====
// Types shared by the gain switch selector and its condition evaluator.
// Assumes the params header is on the include path.
package gain_switch_pkg;
  typedef enum logic [1:0] {GAIN_SET1, GAIN_SET2, GAIN_RETURN_WAIT} gain_state_type;
  typedef enum logic [1:0] {OWNER_NONE, OWNER_NOTCH, OWNER_DAMP} filter_owner_type;
  typedef struct packed {
    logic enable;
    logic [3:0] cond_sel;
    logic [15:0] return_delay;
    logic [15:0] level;
    logic [15:0] hyst;
    logic [15:0] tf_const1;
    logic [15:0] tf_const2;
    logic [1:0] control_mode;
    logic [3:0] autotune_mode;
    logic [15:0] notch_freq;
    logic [15:0] vib_freq;
  } gain_cfg_type;
  typedef struct packed {
    logic [15:0] torque_delta;
    logic [15:0] cmd_speed;
    logic [15:0] motor_speed;
    logic [15:0] pos_dev;
    logic pulses;
    logic done;
  } gain_meas_type;
  // Absolute value of a signed 16-bit quantity
  function automatic logic [15:0] magnitude(input logic [15:0] v);
    magnitude = v[15] ? 16'(16'h0000 - v) : v;
  endfunction
endpackage

// ==== rtl/gain_condition_eval.sv ====
// Evaluates the selected switching condition against level and hysteresis.
// Assumes magnitudes already formed by the caller; purely combinational.
`timescale 1ns/1ps
module gain_condition_eval (
  input wire logic [3:0] cond_sel, // Selected condition
  input wire logic [15:0] level, // Switch level
  input wire logic [15:0] hyst, // Hysteresis
  input wire gain_switch_pkg::gain_meas_type meas, // Measured quantities
  output logic go_high, // Condition calls for gain set 2
  output logic may_return // Condition allows return to set 1
);
  logic [15:0] mag;
  logic [15:0] low_thr;
  // Pick the quantity and compare with level and level minus hysteresis
  always_comb begin
    case (cond_sel)
      4'h3: mag = meas.torque_delta;
      4'h5: mag = meas.cmd_speed;
      4'h6: mag = meas.pos_dev;
      default: mag = meas.motor_speed;
    endcase
    low_thr = (level > hyst) ? 16'(level - hyst) : 16'h0000;
    case (cond_sel)
      4'h7: begin
        go_high = meas.pulses;
        may_return = !meas.pulses;
      end
      4'h8: begin
        go_high = !meas.done;
        may_return = meas.done;
      end
      4'ha: begin
        go_high = meas.pulses || (meas.cmd_speed > level);
        may_return = !meas.pulses && (meas.cmd_speed < low_thr);
      end
      default: begin
        go_high = mag > level;
        may_return = mag < low_thr;
      end
    endcase
  end
endmodule

// ==== rtl/servo_gain_switch_selector.sv ====
// Gain set selector with filter and damping enables, registers on AXI4-Lite.
// Assumes measured inputs synchronous to CORE_CLK and a single synchronous reset.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gain_switch_params.svh"
// Function
// - Switching only when function enable is one
// - Conditions 0 and 4 keep gain set 1
// - Condition 1 keeps gain set 2
// - Condition 2 follows external gain select input
// - Condition 3 uses torque change per 166us
// - Condition 5 uses commanded speed, return delay
// - Condition 6 uses position deviation, return delay
// - Condition 7 set 2 while pulses arrive
// - Condition 8 set 2 while positioning not done
// - Condition 9 uses actual motor speed
// - Condition 10 combines pulses and speed
// - Return delay only on set 2 to 1
// - Torque filter constant follows active gain set
// - Adaptive table index is read only
// - Mode 0 damping needs autotune and notch off
// - Vibration frequency 0 to 99 is invalid
// - Mode 0 notch and damping exclusive, first wins
module servo_gain_switch_selector #(
  parameter int WINDOW_CYCLES = `GS_WINDOW_CYCLES // Cycles in one 166 us window
) (
  input wire logic CORE_CLK, // Core clock, 250 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic [7:0] AWADDR, // Write address
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write byte strobes
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  output logic [1:0] BRESP, // Write response
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  input wire logic [7:0] ARADDR, // Read address
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  output logic RVALID, // Read data valid
  input wire logic RREADY, // Read data ready
  input wire logic GAIN_SELECT_INPUT, // External gain select level
  input wire logic POSITIONING_DONE_SIGNAL, // Positioning completed
  input wire logic COMMAND_PULSE_ACTIVE, // Command pulses being received
  input wire logic [15:0] TORQUE_COMMAND, // Torque command, signed, 0.05 % units
  input wire logic [15:0] COMMAND_SPEED, // Commanded speed, signed, r/min
  input wire logic [15:0] MOTOR_SPEED, // Actual speed, signed, r/min
  input wire logic [15:0] POSITION_DEVIATION, // Position deviation, signed, pulses
  input wire logic [7:0] ADAPTIVE_TABLE_INDEX, // Table entry of adaptive frequency
  output logic GAIN_SET2_ACTIVE, // Gain set 2 in use
  output logic [15:0] TORQUE_FILTER_CONST, // Active torque filter constant
  output logic ADAPTIVE_FILTER_ENABLE, // Adaptive notch enabled
  output logic NOTCH1_ENABLE, // Notch filter 1 enabled
  output logic DAMPING_ENABLE // Damping control enabled
);
  logic [31:0] regs [`GS_REG_COUNT];
  logic [31:0] next_regs [`GS_REG_COUNT];
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [16:0] win_count, next_win_count;
  logic [15:0] torque_ref, next_torque_ref;
  logic [15:0] ret_count, next_ret_count;
  gain_switch_pkg::gain_state_type state, next_state;
  gain_switch_pkg::filter_owner_type owner, next_owner;
  gain_switch_pkg::gain_cfg_type cfg;
  gain_switch_pkg::gain_meas_type meas;
  logic tick, go_high, may_return, notch_cfg, damp_cfg, adaptive_calc, notch_calc, damp_calc;
  logic [15:0] tf_calc;

  // Writable bits of each register; the rest read as zero
  function automatic logic [31:0] reg_mask(input int idx);
    case (idx)
      0: reg_mask = 32'h0000_00f1;
      4: reg_mask = 32'hffff_ffff;
      5: reg_mask = 32'h0000_00f3;
      6, 7: reg_mask = 32'h00ff_ffff;
      default: reg_mask = 32'h0000_ffff;
    endcase
  endfunction

  // Reset value of each register
  function automatic logic [31:0] reg_reset(input int idx);
    case (idx)
      4: reg_reset = `GS_RST_TFILT;
      6: reg_reset = `GS_RST_NOTCH;
      default: reg_reset = 32'h0000_0000;
    endcase
  endfunction

  // Fields of the configuration registers
  assign cfg.enable = regs[0][`GS_CTRL_EN_BIT];
  assign cfg.cond_sel = regs[0][`GS_CTRL_SEL_LSB +: 4];
  assign cfg.return_delay = regs[1][15:0];
  assign cfg.level = regs[2][15:0];
  assign cfg.hyst = regs[3][15:0];
  assign cfg.tf_const1 = regs[4][15:0];
  assign cfg.tf_const2 = regs[4][`GS_HI_FIELD_LSB +: 16];
  assign cfg.control_mode = regs[5][1:0];
  assign cfg.autotune_mode = regs[5][`GS_MODE_AUTOTUNE_LSB +: 4];
  assign cfg.notch_freq = regs[6][15:0];
  assign cfg.vib_freq = regs[7][15:0];

  // Bus handshakes
  assign AWREADY = !aw_held;
  assign WREADY = !w_held;
  assign ARREADY = !rvalid;
  assign BVALID = bvalid;
  assign BRESP = bresp;
  assign RVALID = rvalid;
  assign RRESP = rresp;
  assign RDATA = rdata;

  // Bus slave: hold address and data, write when both are in, answer reads
  always_comb begin
    next_regs = regs;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !BREADY;
    next_bresp = bresp;
    next_rvalid = rvalid && !RREADY;
    next_rresp = rresp;
    next_rdata = rdata;
    if (AWVALID && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr[7:2] <= 6'(`GS_STATUS_INDEX)) ? `GS_RESP_OKAY : `GS_RESP_DECERR;
      for (int i = 0; i < `GS_REG_COUNT; i++) begin
        if (aw_addr[7:2] == 6'(i)) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
              next_regs[i][8*b +: 8] = w_data[8*b +: 8] & 8'(reg_mask(i) >> (8 * b));
            end
          end
        end
      end
    end
    if (ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `GS_RESP_OKAY;
      if (ARADDR[7:2] < 6'(`GS_REG_COUNT)) begin
        next_rdata = regs[ARADDR[4:2]];
      end else if (ARADDR[7:2] == 6'(`GS_STATUS_INDEX)) begin
        // Status word; the table index can only be read
        next_rdata = {16'h0000, ADAPTIVE_TABLE_INDEX, 3'h0, NOTCH1_ENABLE, DAMPING_ENABLE,
                      ADAPTIVE_FILTER_ENABLE, GAIN_SET2_ACTIVE, (state == gain_switch_pkg::GAIN_RETURN_WAIT)};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = `GS_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < `GS_REG_COUNT; i++) begin
        regs[i] <= reg_reset(i);
      end
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      regs <= next_regs;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Measured quantities as magnitudes
  assign meas.torque_delta = gain_switch_pkg::magnitude(16'(TORQUE_COMMAND - torque_ref));
  assign meas.cmd_speed = gain_switch_pkg::magnitude(COMMAND_SPEED);
  assign meas.motor_speed = gain_switch_pkg::magnitude(MOTOR_SPEED);
  assign meas.pos_dev = gain_switch_pkg::magnitude(POSITION_DEVIATION);
  assign meas.pulses = COMMAND_PULSE_ACTIVE;
  assign meas.done = POSITIONING_DONE_SIGNAL;
  assign tick = (win_count == 17'(WINDOW_CYCLES - 1));

  gain_condition_eval u_eval (
    .cond_sel(cfg.cond_sel),
    .level(cfg.level),
    .hyst(cfg.hyst),
    .meas(meas),
    .go_high(go_high),
    .may_return(may_return)
  );

  // Gain set state, window timer and return delay
  always_comb begin
    next_state = state;
    next_ret_count = ret_count;
    next_win_count = tick ? 17'h0_0000 : 17'(win_count + 17'h0_0001);
    next_torque_ref = tick ? TORQUE_COMMAND : torque_ref;
    if (!cfg.enable) begin
      next_state = gain_switch_pkg::GAIN_SET1;
    end else begin
      case (cfg.cond_sel)
        4'h1: next_state = gain_switch_pkg::GAIN_SET2;
        4'h2: next_state = GAIN_SELECT_INPUT ? gain_switch_pkg::GAIN_SET2 : gain_switch_pkg::GAIN_SET1;
        4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha: begin
          case (state)
            gain_switch_pkg::GAIN_SET1: begin
              if (go_high) next_state = gain_switch_pkg::GAIN_SET2;
            end
            gain_switch_pkg::GAIN_SET2: begin
              if (may_return) begin
                next_ret_count = 16'h0000;
                next_state = (cfg.return_delay == 16'h0000) ? gain_switch_pkg::GAIN_SET1
                                                            : gain_switch_pkg::GAIN_RETURN_WAIT;
              end
            end
            gain_switch_pkg::GAIN_RETURN_WAIT: begin
              if (go_high || !may_return) begin
                next_state = gain_switch_pkg::GAIN_SET2;
              end else if (ret_count >= cfg.return_delay) begin
                next_state = gain_switch_pkg::GAIN_SET1;
              end else if (tick) begin
                next_ret_count = 16'(ret_count + 16'h0001);
              end
            end
            default: next_state = gain_switch_pkg::GAIN_SET1;
          endcase
        end
        default: next_state = gain_switch_pkg::GAIN_SET1;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state <= gain_switch_pkg::GAIN_SET1;
      ret_count <= 16'h0000;
      win_count <= 17'h0_0000;
      torque_ref <= 16'h0000;
    end else begin
      state <= next_state;
      ret_count <= next_ret_count;
      win_count <= next_win_count;
      torque_ref <= next_torque_ref;
    end
  end

  // Filter enables and the active torque filter constant
  always_comb begin
    notch_cfg = cfg.notch_freq != `GS_NOTCH_OFF_FREQ;
    damp_cfg = cfg.vib_freq >= `GS_VIB_MIN_VALID;
    case (owner)
      gain_switch_pkg::OWNER_NOTCH: next_owner = notch_cfg ? owner : gain_switch_pkg::OWNER_NONE;
      gain_switch_pkg::OWNER_DAMP: next_owner = damp_cfg ? owner : gain_switch_pkg::OWNER_NONE;
      default: begin
        if (notch_cfg) next_owner = gain_switch_pkg::OWNER_NOTCH;
        else if (damp_cfg) next_owner = gain_switch_pkg::OWNER_DAMP;
        else next_owner = gain_switch_pkg::OWNER_NONE;
      end
    endcase
    adaptive_calc = (cfg.control_mode == 2'h2) && ((cfg.autotune_mode >= 4'h1 && cfg.autotune_mode <= 4'h3)
                    || cfg.autotune_mode == 4'h7);
    notch_calc = notch_cfg && !(cfg.control_mode == 2'h0 && owner == gain_switch_pkg::OWNER_DAMP);
    damp_calc = damp_cfg && ((cfg.control_mode == 2'h2) || (cfg.control_mode == 2'h0
                && cfg.autotune_mode == 4'h0 && owner == gain_switch_pkg::OWNER_DAMP));
    tf_calc = (state == gain_switch_pkg::GAIN_SET1) ? cfg.tf_const1 : cfg.tf_const2;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      owner <= gain_switch_pkg::OWNER_NONE;
      ADAPTIVE_FILTER_ENABLE <= 1'b0;
      NOTCH1_ENABLE <= 1'b0;
      DAMPING_ENABLE <= 1'b0;
      TORQUE_FILTER_CONST <= 16'h0000;
      GAIN_SET2_ACTIVE <= 1'b0;
    end else begin
      owner <= next_owner;
      ADAPTIVE_FILTER_ENABLE <= adaptive_calc;
      NOTCH1_ENABLE <= notch_calc;
      DAMPING_ENABLE <= damp_calc;
      TORQUE_FILTER_CONST <= tf_calc;
      GAIN_SET2_ACTIVE <= (next_state != gain_switch_pkg::GAIN_SET1);
    end
  end

  // Checks on the selection and enable behaviour
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_disabled_set1; !cfg.enable |=> !GAIN_SET2_ACTIVE ##1 !GAIN_SET2_ACTIVE || cfg.enable; endproperty
  a_disabled_set1: assert property (p_disabled_set1) else $error("gain set 2 while disabled");
  property p_fixed_set1; cfg.enable && (cfg.cond_sel == 4'h0 || cfg.cond_sel == 4'h4) |-> ##1 !GAIN_SET2_ACTIVE;
  endproperty
  a_fixed_set1: assert property (p_fixed_set1) else $error("fixed set 1 not held");
  property p_fixed_set2; cfg.enable && cfg.cond_sel == 4'h1 |=> GAIN_SET2_ACTIVE; endproperty
  a_fixed_set2: assert property (p_fixed_set2) else $error("fixed set 2 not held");
  property p_external; cfg.enable && cfg.cond_sel == 4'h2 |=> GAIN_SET2_ACTIVE == $past(GAIN_SELECT_INPUT); endproperty
  a_external: assert property (p_external) else $error("external select not followed");
  property p_rise; cfg.enable && cfg.cond_sel == 4'h5 && state == gain_switch_pkg::GAIN_SET1 && go_high
    |=> GAIN_SET2_ACTIVE; endproperty
  a_rise: assert property (p_rise) else $error("no rise to set 2");
  property p_return_delay; cfg.enable && cfg.cond_sel == 4'h9 && state == gain_switch_pkg::GAIN_SET2 && may_return
    && cfg.return_delay != 16'h0000 |=> state == gain_switch_pkg::GAIN_RETURN_WAIT && GAIN_SET2_ACTIVE; endproperty
  a_return_delay: assert property (p_return_delay) else $error("return skipped delay");
  property p_tfilt; !$past(RST) |-> TORQUE_FILTER_CONST == ($past(state) == gain_switch_pkg::GAIN_SET1
    ? $past(cfg.tf_const1) : $past(cfg.tf_const2)); endproperty
  a_tfilt: assert property (p_tfilt) else $error("wrong torque filter constant");
  property p_adaptive; ADAPTIVE_FILTER_ENABLE |-> $past(cfg.control_mode) == 2'h2; endproperty
  a_adaptive: assert property (p_adaptive) else $error("adaptive filter outside mode 2");
  property p_damp_mode0; cfg.control_mode == 2'h0 && cfg.autotune_mode != 4'h0 |=> !DAMPING_ENABLE; endproperty
  a_damp_mode0: assert property (p_damp_mode0) else $error("damping with autotune in mode 0");
  property p_vib_invalid; cfg.vib_freq < `GS_VIB_MIN_VALID |=> !DAMPING_ENABLE; endproperty
  a_vib_invalid: assert property (p_vib_invalid) else $error("damping with invalid frequency");
  property p_exclusive; $past(cfg.control_mode) == 2'h0 |-> !(NOTCH1_ENABLE && DAMPING_ENABLE); endproperty
  a_exclusive: assert property (p_exclusive) else $error("notch and damping together");

  c_return: cover property (state == gain_switch_pkg::GAIN_RETURN_WAIT ##1 state == gain_switch_pkg::GAIN_SET1);
  c_external: cover property (cfg.cond_sel == 4'h2 && GAIN_SET2_ACTIVE);
  c_damping: cover property (DAMPING_ENABLE && cfg.control_mode == 2'h0);
endmodule

// ==== verification/loop_model.sv ====
// Model of the drive control loop: registers the bench's demands onto the measured inputs.
// Assumes demands change just after a rising edge of the core clock.
`timescale 1ns/1ps
module loop_model (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [6:0][15:0] dem, // Demanded cmd, motor, dev, torque, pulses, done, index
  output logic [15:0] cmd_speed, // Commanded speed
  output logic [15:0] motor_speed, // Actual speed
  output logic [15:0] pos_dev, // Position deviation
  output logic [15:0] torque, // Torque command
  output logic pulses, // Command pulses arriving
  output logic done, // Positioning completed
  output logic [7:0] table_index // Adaptive table entry
);
  // Loop quantities follow the demands one cycle later; at rest the axis counts as done
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_speed <= 16'h0000;
      motor_speed <= 16'h0000;
      pos_dev <= 16'h0000;
      torque <= 16'h0000;
      pulses <= 1'b0;
      done <= 1'b1;
    end else begin
      cmd_speed <= dem[0];
      motor_speed <= dem[1];
      pos_dev <= dem[2];
      torque <= dem[3];
      pulses <= dem[4][0];
      done <= dem[5][0];
    end
    table_index <= dem[6][7:0];
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench of the gain switch selector over its register bus.
// Assumes the design package and params header are compiled and on the include path.
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, gain_select_input = 1'b0, set2, ada, n1, damp, pul, dn;
  logic [1:0] bresp, rresp;
  logic [15:0] tf, cs, ms, pd, tq;
  logic [7:0] idx;
  logic [6:0][15:0] dem = {16'h005a, 16'h0001, 80'h0};
  int error_cnt = 0, tests_run = 0, cycles = 0;
  localparam logic [7:0] fx_ctrl [8] = '{8'h11, 8'h10, 8'h01, 8'h11, 8'h41, 8'h21, 8'hb1, 8'h21};
  localparam logic fx_gain_select_input [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  localparam logic fx_exp [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [7:0] cc_ctrl [7] = '{8'h51, 8'h91, 8'h61, 8'h31, 8'h71, 8'h81, 8'ha1};
  localparam int cc_k [7] = '{0, 1, 2, 3, 4, 5, 4};
  localparam logic [15:0] cc_hi [7] = '{16'h0096, 16'h0096, 16'hff6a, 16'h012c, 16'h1, 16'h0, 16'h1};
  localparam logic [15:0] cc_mid [7] = '{16'h005a, 16'h005a, 16'hffa6, 16'h012c, 16'h1, 16'h0, 16'h1};
  localparam logic [15:0] cc_lo [7] = '{16'h0032, 16'h0032, 16'hffce, 16'h012c, 16'h0, 16'h1, 16'h0};
  servo_gain_switch_selector #(.WINDOW_CYCLES(8)) servo_gain_switch_selector_i (.CORE_CLK(core_clk), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .GAIN_SELECT_INPUT(gain_select_input),
    .POSITIONING_DONE_SIGNAL(dn), .COMMAND_PULSE_ACTIVE(pul), .TORQUE_COMMAND(tq), .COMMAND_SPEED(cs),
    .MOTOR_SPEED(ms), .POSITION_DEVIATION(pd), .ADAPTIVE_TABLE_INDEX(idx), .GAIN_SET2_ACTIVE(set2),
    .TORQUE_FILTER_CONST(tf), .ADAPTIVE_FILTER_ENABLE(ada), .NOTCH1_ENABLE(n1), .DAMPING_ENABLE(damp));
  loop_model loop_model_i (.clk(core_clk), .rst(rst), .dem(dem), .cmd_speed(cs), .motor_speed(ms), .pos_dev(pd),
    .torque(tq), .pulses(pul), .done(dn), .table_index(idx));
  // Clock at 250 MHz
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Write cycle: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!bvalid);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  // Read cycle with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask
  // Level and event conditions: rise and return; conditions 5, 9 and 6 also hold inside hysteresis and delayed return
  task automatic run_cond(input int i);
    dem[4:0] <= 80'h0;
    dem[5] <= 16'h0001;
    wr(8'h00, {24'h0, cc_ctrl[i]}, 2'h0);
    dem[cc_k[i]] <= cc_hi[i];
    cyc(12);
    chk("cond_rise", 32'h1, {31'h0, set2});
    if (cc_mid[i] !== cc_hi[i]) begin
      dem[cc_k[i]] <= cc_mid[i];
      cyc(40);
      chk("cond_hyst", 32'h1, {31'h0, set2});
      dem[cc_k[i]] <= cc_lo[i];
      cyc(4);
      chk("cond_delay", 32'h1, {31'h0, set2});
    end else dem[cc_k[i]] <= cc_lo[i];
    cyc(40);
    chk("cond_fall", 32'h0, {31'h0, set2});
  endtask
  // Main sequence: reset, registers, fixed rows, condition rows, filter enables
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    chk("awready", 32'h1, {31'h0, awready});
    chk("gain_set2", 32'h0, {31'h0, set2});
    rd(8'h20, 32'h0000_5a00, 2'h0);
    wr(8'h20, 32'hffff_ffff, 2'h0);
    rd(8'h20, 32'h0000_5a00, 2'h0);
    rd(8'h10, 32'h0098_0098, 2'h0);
    rd(8'h18, 32'h0002_05dc, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    wr(8'h24, 32'h1, 2'h3);
    rd(8'h24, 32'h0, 2'h3);
    chk("torque_const", 32'h0098, {16'h0, tf});
    wr(8'h10, 32'h0200_0100, 2'h0);
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h08, 32'h64, 2'h0);
    wr(8'h0c, 32'h14, 2'h0);
    rd(8'h08, 32'h64, 2'h0);
    for (int i = 0; i < 8; i++) begin
      gain_select_input <= fx_gain_select_input[i];
      wr(8'h00, {24'h0, fx_ctrl[i]}, 2'h0);
      cyc(3);
      chk("gain_set2", {31'h0, fx_exp[i]}, {31'h0, set2});
      chk("torque_const", fx_exp[i] ? 32'h200 : 32'h100, {16'h0, tf});
    end
    for (int i = 0; i < 7; i++) run_cond(i);
    for (int a = 0; a < 8; a++) begin
      wr(8'h14, 32'(a * 16 + 2), 2'h0);
      cyc(3);
      chk("adaptive", {31'h0, a inside {1, 2, 3, 7}}, {31'h0, ada});
    end
    wr(8'h14, 32'h0, 2'h0);
    wr(8'h1c, 32'h63, 2'h0);
    cyc(3);
    chk("damping", 32'h0, {31'h0, damp});
    wr(8'h14, 32'h10, 2'h0);
    wr(8'h1c, 32'h64, 2'h0);
    cyc(3);
    chk("damping", 32'h0, {31'h0, damp});
    wr(8'h14, 32'h0, 2'h0);
    cyc(3);
    chk("damping", 32'h1, {31'h0, damp});
    wr(8'h18, 32'h0002_01f4, 2'h0);
    cyc(3);
    chk("notch1", 32'h0, {31'h0, n1});
    chk("damping", 32'h1, {31'h0, damp});
    // Reset in mid-run brings registers and enables back to their reset state
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    chk("damping", 32'h0, {31'h0, damp});
    chk("torque_const", 32'h0098, {16'h0, tf});
    rd(8'h18, 32'h0002_05dc, 2'h0);
    end_sim();
  end
endmodule
